// ==== design/learned_table_and_port_statistics.sv ====
// apb readout of the learned address table and per-port statistics
`timescale 1ns/10ps

// How it works
// - host has no path to alter table entries; only learning writes
// - table stores 1K entries, returned as a 72-bit record
// - record bit 71 is 1 when table is empty, 1 after reset
// - bits 70..61 give valid entries minus one when not empty
// - bits 60..59 carry the entry aging stamp
// - bits 58..56 give the learning port, 000 to 100
// - bit 55 is 1 until the entry arrives; host rereads from byte 114
// - data registers 112..120 hold record bytes, top byte first
// - writing low index bits to register 111 starts the read
// - count and empty flag come with every table read
// - each port has its own 32-counter set, port 1 at 0x20..0x3f
// - 0x20/0x21 sum received octets by priority, bad frames included
// - 0x22 short good-checksum frames, 0x23 short errored fragments
// - 0x24 long good frames, 0x25 long errored or over 1916 bytes
// - 0x26 bad symbol; 0x27/0x28 bad checksum whole or odd length
// - 0x29 control-type frames, 0x2a qualified pause frames
// - 0x2b..0x2d good all-station, group, single-station receive frames
// - 0x2e..0x33 count received frames from 64 bytes up to the length limit by length bin
// - 0x34/0x35 transmit octets by priority; 0x37..0x3a transmit kinds
// - 0x36 counts collisions later than 512 bit-times
// - 0x3b..0x3f deferred, all hits, abandoned, one and many hits
// - counter word: bit 31 overflow, bit 30 valid, 29..0 count
// - a counter clears when the host reads it out
// - ports 2, 3, 4 repeat the layout at 0x40, 0x60, 0x80
module learned_table_and_port_statistics (
  input  wire logic                                            pclk,
  input  wire logic                                            presetn,
  input  wire logic                                            psel,
  input  wire logic                                            penable,
  input  wire logic                                            pwrite,
  input  wire logic [11:0]                                     paddr,
  input  wire logic [31:0]                                     pwdata,
  output logic [31:0]                                          prdata,
  output logic                                                 pready,
  output logic                                                 pslverr,
  input  wire sw_mgmt_pkg::learn_wr_t                          learn_wr,
  input  wire sw_mgmt_pkg::rx_frame_t [sw_mgmt_pkg::NUM_PORTS-1:0] rx_frame,
  input  wire sw_mgmt_pkg::tx_frame_t [sw_mgmt_pkg::NUM_PORTS-1:0] tx_frame
);
  import sw_mgmt_pkg::*;

  typedef enum logic {FETCH_IDLE, FETCH_WAIT} fetch_state_t;

  typedef struct packed {
    fetch_state_t fsm;
    logic [7:0]   ctrl;
    logic [7:0]   index_lo;
    rec_t         rec;
    logic         long_max;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } top_state_t;

  localparam top_state_t ST_RST = '{
    fsm:      FETCH_IDLE,
    ctrl:     CTRL_RST,
    index_lo: ADDR_RST,
    rec:      REC_RST,
    long_max: CONFIG_RST,
    prdata:   32'h0,
    pready:   1'b0,
    pslverr:  1'b0
  };

  ////////////////////////////////////////////////////////////////////
  // helper functions

  // word index of an aligned byte address, top bit says in range
  function automatic logic [8:0] word_index(input logic [11:0] a);
    word_index = {(a[11:10] == 2'b00) && (a[1:0] == 2'b00), a[9:2]};
  endfunction

  // record byte for a data register, 112 holds bits 71..64
  function automatic logic [7:0] rec_byte(input rec_t r, input logic [7:0] idx);
    logic [7:0] sh;
    sh = IDX_DATA_LAST - idx;
    rec_byte = r[{sh[3:0], 3'b000} +: 8];
  endfunction

  // receive classification into per-counter increments
  function automatic ctr_add_t rx_adds(input rx_frame_t f, input logic long_max);
    logic [10:0] lim;
    logic        bad;
    logic        in_range;
    rx_adds = '0;
    lim = long_max ? LEN_ALT_MAX : LEN_STD_MAX;
    bad = !f.crc_ok || f.symbol_err || f.odd_bits;
    in_range = (f.len >= LEN_MIN) && (f.len <= lim);
    if (f.done) begin
      // octets of every frame, errored ones too
      rx_adds[f.hi_prio ? RX_HIGH_PRIO_OCTETS : RX_LOW_PRIO_OCTETS] = f.len;
      if (f.len < LEN_MIN) begin
        rx_adds[bad ? RX_SHORT_BAD_FRAMES : RX_SHORT_GOOD_FRAMES] = ADD_ONE;
      end
      if (!bad && (f.len > lim)) begin
        rx_adds[RX_LONG_GOOD_FRAMES] = ADD_ONE;
      end
      if ((bad && (f.len > LEN_STD_MAX)) || (f.len > LEN_JABBER)) begin
        rx_adds[RX_LONG_BAD_FRAMES] = ADD_ONE;
      end
      if (f.symbol_err) begin
        rx_adds[RX_BAD_SYMBOL_FRAMES] = ADD_ONE;
      end
      if (in_range && !f.crc_ok) begin
        rx_adds[f.odd_bits ? RX_MISALIGNED_FRAMES : RX_CHECKSUM_FAIL_FRAMES] = ADD_ONE;
      end
      if (f.mac_ctrl) begin
        rx_adds[RX_MAC_CONTROL_FRAMES] = ADD_ONE;
      end
      // pause qualification itself is done by the mac
      if (f.mac_ctrl && f.pause_ok) begin
        rx_adds[RX_FLOW_PAUSE_FRAMES] = ADD_ONE;
      end
      // destination kinds, good frames only
      if (!bad && in_range) begin
        if (f.all_station) begin
          rx_adds[RX_ALL_STATION_FRAMES] = ADD_ONE;
        end else if (f.group) begin
          if (!f.mac_ctrl) begin
            rx_adds[RX_GROUP_FRAMES] = ADD_ONE;
          end
        end else begin
          rx_adds[RX_SINGLE_STATION_FRAMES] = ADD_ONE;
        end
      end
      // length bins, bad frames included
      if (f.len == LEN_MIN) begin
        rx_adds[RX_LEN_MIN_BIN] = ADD_ONE;
      end else if (f.len > LEN_MIN && f.len <= LEN_BIN1) begin
        rx_adds[RX_LEN_BIN_65] = ADD_ONE;
      end else if (f.len > LEN_BIN1 && f.len <= LEN_BIN2) begin
        rx_adds[RX_LEN_BIN_128] = ADD_ONE;
      end else if (f.len > LEN_BIN2 && f.len <= LEN_BIN3) begin
        rx_adds[RX_LEN_BIN_256] = ADD_ONE;
      end else if (f.len > LEN_BIN3 && f.len <= LEN_BIN4) begin
        rx_adds[RX_LEN_BIN_512] = ADD_ONE;
      end else if (f.len > LEN_BIN4 && f.len <= lim) begin
        rx_adds[RX_LEN_TOP_BIN] = ADD_ONE;
      end
    end
  endfunction

  // transmit classification; hits are reported in half duplex only
  function automatic ctr_add_t tx_adds(input tx_frame_t f);
    tx_adds = '0;
    if (f.done) begin
      if (!f.abandoned) begin
        tx_adds[f.hi_prio ? TX_HIGH_PRIO_OCTETS : TX_LOW_PRIO_OCTETS] = f.len;
        if (f.pause) begin
          tx_adds[TX_FLOW_PAUSE_FRAMES] = ADD_ONE;
        end else if (f.all_station) begin
          tx_adds[TX_ALL_STATION_FRAMES] = ADD_ONE;
        end else if (f.group) begin
          tx_adds[TX_GROUP_FRAMES] = ADD_ONE;
        end else begin
          tx_adds[TX_SINGLE_STATION_FRAMES] = ADD_ONE;
        end
        if (f.hits == 4'h1) begin
          tx_adds[TX_ONE_HIT_COUNT] = ADD_ONE;
        end else if (f.hits > 4'h1) begin
          tx_adds[TX_MANY_HITS_COUNT] = ADD_ONE;
        end
      end else begin
        tx_adds[TX_ABANDONED_COUNT] = ADD_ONE;
      end
      if (f.late_hit) begin
        tx_adds[TX_LATE_HIT_COUNT] = ADD_ONE;
      end
      if (f.deferred) begin
        tx_adds[TX_DELAYED_START_COUNT] = ADD_ONE;
      end
      tx_adds[TX_ALL_HITS_COUNT] = {7'h00, f.hits};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state and bus decode

  top_state_t           st;
  top_state_t           nxt;
  logic                 setup;
  logic                 apb_wr;
  logic [8:0]           ridx;
  logic                 trig;
  logic                 tbl_trig;
  logic                 mib_trig;
  logic [9:0]           ind_addr;
  logic [4:0]           blk_m1;
  logic                 blk_ok;
  logic [NUM_PORTS-1:0] bank_rd;
  ctr_add_t             port_add  [NUM_PORTS];
  mib_word_t            port_word [NUM_PORTS];
  logic                 tbl_done;
  entry_t               tbl_entry;
  logic                 tbl_hit;
  logic [10:0]          tbl_count;
  logic [10:0]          cnt_m1;

  // answer is prepared in the setup cycle, write lands at access end
  assign setup  = psel && !penable;
  assign apb_wr = psel && penable && st.pready && pwrite;
  assign ridx   = word_index(paddr);

  // a write of the low index starts the selected indirect read
  assign trig     = apb_wr && ridx[8] && (ridx[7:0] == IDX_ADDR);
  assign tbl_trig = trig && (st.ctrl[4:2] == SEL_TBL_RD);
  assign mib_trig = trig && (st.ctrl[4:2] == SEL_MIB_RD);
  assign ind_addr = {st.ctrl[1:0], pwdata[7:0]};
  assign blk_m1   = ind_addr[9:5] - MIB_BLK_FIRST;
  assign blk_ok   = (ind_addr[9:5] >= MIB_BLK_FIRST) && (ind_addr[9:5] <= MIB_BLK_LAST);
  assign cnt_m1   = tbl_count - ADD_ONE;

  ////////////////////////////////////////////////////////////////////
  // per-port counter banks

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    assign port_add[p] = rx_adds(rx_frame[p], st.long_max) | tx_adds(tx_frame[p]);
    // block p+1 of the counter space belongs to port p
    assign bank_rd[p] = mib_trig && (ind_addr[9:5] == 5'(p + 1));
    stat_counter_bank u_bank (
      .pclk    (pclk),
      .presetn (presetn),
      .add     (port_add[p]),
      .rd_en   (bank_rd[p]),
      .rd_idx  (ind_addr[4:0]),
      .rd_word (port_word[p])
    );
  end

  ////////////////////////////////////////////////////////////////////
  // learned table

  learned_table u_table (
    .pclk       (pclk),
    .presetn    (presetn),
    .learn      (learn_wr),
    .rd_en      (tbl_trig),
    .rd_index   (ind_addr),
    .rd_done    (tbl_done),
    .rd_entry   (tbl_entry),
    .rd_present (tbl_hit),
    .count      (tbl_count)
  );

  ////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0] rd_val;
    logic        rd_hit;
    rd_val = '0;
    rd_hit = 1'b1;
    nxt = st;
    nxt.pready = 1'b0;

    // read value for the address on the bus
    if (!ridx[8]) begin
      rd_hit = 1'b0;
    end else if (ridx[7:0] == IDX_CTRL) begin
      rd_val = {24'h0, st.ctrl};
    end else if (ridx[7:0] == IDX_ADDR) begin
      rd_val = {24'h0, st.index_lo};
    end else if (ridx[7:0] >= IDX_DATA0 && ridx[7:0] <= IDX_DATA_LAST) begin
      rd_val = {24'h0, rec_byte(st.rec, ridx[7:0])};
    end else if (ridx[7:0] == IDX_STATUS) begin
      rd_val = {st.fsm == FETCH_WAIT, 20'h0, tbl_count};
    end else if (ridx[7:0] == IDX_CONFIG) begin
      rd_val = {31'h0, st.long_max};
    end else begin
      rd_hit = 1'b0;
    end

    // zero-wait answer: pready rises in the first access cycle
    if (setup) begin
      nxt.pready = 1'b1;
      nxt.pslverr = !rd_hit;
      nxt.prdata = pwrite ? 32'h0 : rd_val;
    end

    // table result arrives; occupancy rides along on every read
    if (st.fsm == FETCH_WAIT && tbl_done) begin
      nxt.fsm = FETCH_IDLE;
      nxt.rec.table_empty_flag = (tbl_count == 11'h000);
      nxt.rec.occupied_entry_count = (tbl_count == 11'h000) ? 10'h000 : cnt_m1[9:0];
      nxt.rec.aging = tbl_hit ? tbl_entry.aging : 2'h0;
      nxt.rec.src_port = tbl_hit ? tbl_entry.src_port : 3'h0;
      nxt.rec.filter_group_id = tbl_hit ? tbl_entry.filter_group_id : 7'h00;
      nxt.rec.station_addr = tbl_hit ? tbl_entry.station_addr : 48'h0;
      nxt.rec.not_ready = 1'b0;
    end

    // register writes; data registers and status ignore writes
    if (apb_wr && ridx[8]) begin
      if (ridx[7:0] == IDX_CTRL) begin
        nxt.ctrl = pwdata[7:0];
      end
      if (ridx[7:0] == IDX_CONFIG) begin
        nxt.long_max = pwdata[0];
      end
      if (ridx[7:0] == IDX_ADDR) begin
        nxt.index_lo = pwdata[7:0];
      end
    end

    // a new trigger overrides any result landing in the same cycle
    // occupancy is known at once, so the flag and count in bytes 112..113 are valid before the entry lands
    if (tbl_trig) begin
      nxt.fsm = FETCH_WAIT;
      nxt.rec = REC_RST;
      nxt.rec.table_empty_flag = (tbl_count == 11'h000);
      nxt.rec.occupied_entry_count = (tbl_count == 11'h000) ? 10'h000 : cnt_m1[9:0];
      nxt.rec.not_ready = 1'b1;
    end else if (mib_trig) begin
      nxt.fsm = FETCH_IDLE;
      nxt.rec = '0;
      if (blk_ok) begin
        nxt.rec[31:0] = port_word[blk_m1[1:0]];
      end
    end
    // other selections leave table and record alone
  end

  // record stays until the next trigger since only triggers and their fetch results load it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_RST;
    end else begin
      st <= nxt;
    end
  end

  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;
endmodule

// ==== design/sw_mgmt_pkg.sv ====
// shared constants and types for the learned table and statistics readout
package sw_mgmt_pkg;
  localparam int NUM_PORTS = 4;
  localparam int TBL_DEPTH = 1024;
  localparam int NUM_CTRS  = 32;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL      = 8'h6e;
  localparam logic [7:0] IDX_ADDR      = 8'h6f;
  localparam logic [7:0] IDX_DATA0     = 8'h70;
  localparam logic [7:0] IDX_DATA_LAST = 8'h78;
  localparam logic [7:0] IDX_STATUS    = 8'h79;
  localparam logic [7:0] IDX_CONFIG    = 8'h7a;

  // reset values
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam logic [7:0] ADDR_RST   = 8'h00;
  localparam logic       CONFIG_RST = 1'b0;

  // selection field of the indirect control value, bits 4..2
  localparam logic [2:0] SEL_TBL_RD = 3'h6;
  localparam logic [2:0] SEL_MIB_RD = 3'h7;

  // counter blocks of 32 words, ports 1..4 at blocks 1..4
  localparam logic [4:0] MIB_BLK_FIRST = 5'h01;
  localparam logic [4:0] MIB_BLK_LAST  = 5'h04;

  // frame length limits in bytes
  localparam logic [10:0] LEN_MIN     = 11'd64;
  localparam logic [10:0] LEN_BIN1    = 11'd127;
  localparam logic [10:0] LEN_BIN2    = 11'd255;
  localparam logic [10:0] LEN_BIN3    = 11'd511;
  localparam logic [10:0] LEN_BIN4    = 11'd1023;
  localparam logic [10:0] LEN_STD_MAX = 11'd1522;
  localparam logic [10:0] LEN_ALT_MAX = 11'd1536;
  localparam logic [10:0] LEN_JABBER  = 11'd1916;
  localparam logic [10:0] ADD_ONE     = 11'd1;

  // counter offsets within a port block
  localparam int RX_LOW_PRIO_OCTETS = 'h00, RX_HIGH_PRIO_OCTETS = 'h01,
    RX_SHORT_GOOD_FRAMES = 'h02, RX_SHORT_BAD_FRAMES = 'h03,
    RX_LONG_GOOD_FRAMES = 'h04, RX_LONG_BAD_FRAMES = 'h05,
    RX_BAD_SYMBOL_FRAMES = 'h06, RX_CHECKSUM_FAIL_FRAMES = 'h07,
    RX_MISALIGNED_FRAMES = 'h08, RX_MAC_CONTROL_FRAMES = 'h09,
    RX_FLOW_PAUSE_FRAMES = 'h0a, RX_ALL_STATION_FRAMES = 'h0b,
    RX_GROUP_FRAMES = 'h0c, RX_SINGLE_STATION_FRAMES = 'h0d,
    RX_LEN_MIN_BIN = 'h0e, RX_LEN_BIN_65 = 'h0f, RX_LEN_BIN_128 = 'h10,
    RX_LEN_BIN_256 = 'h11, RX_LEN_BIN_512 = 'h12, RX_LEN_TOP_BIN = 'h13,
    TX_LOW_PRIO_OCTETS = 'h14, TX_HIGH_PRIO_OCTETS = 'h15,
    TX_LATE_HIT_COUNT = 'h16, TX_FLOW_PAUSE_FRAMES = 'h17,
    TX_ALL_STATION_FRAMES = 'h18, TX_GROUP_FRAMES = 'h19,
    TX_SINGLE_STATION_FRAMES = 'h1a, TX_DELAYED_START_COUNT = 'h1b,
    TX_ALL_HITS_COUNT = 'h1c, TX_ABANDONED_COUNT = 'h1d,
    TX_ONE_HIT_COUNT = 'h1e, TX_MANY_HITS_COUNT = 'h1f;

  typedef struct packed {
    logic [1:0]  aging;
    logic [2:0]  src_port;
    logic [6:0]  filter_group_id;
    logic [47:0] station_addr;
  } entry_t;

  typedef struct packed {
    logic       en;
    logic [9:0] index;
    logic       keep;
    entry_t     entry;
  } learn_wr_t;

  typedef struct packed {
    logic        table_empty_flag;
    logic [9:0]  occupied_entry_count;
    logic [1:0]  aging;
    logic [2:0]  src_port;
    logic        not_ready;
    logic [6:0]  filter_group_id;
    logic [47:0] station_addr;
  } rec_t;

  localparam rec_t REC_RST = '{table_empty_flag: 1'b1, default: '0};

  typedef struct packed {
    logic        overflow;
    logic        valid;
    logic [29:0] count;
  } mib_word_t;

  typedef struct packed {
    logic        done;
    logic [10:0] len;
    logic        crc_ok;
    logic        symbol_err;
    logic        odd_bits;
    logic        hi_prio;
    logic        all_station;
    logic        group;
    logic        mac_ctrl;
    logic        pause_ok;
  } rx_frame_t;

  typedef struct packed {
    logic        done;
    logic [10:0] len;
    logic        hi_prio;
    logic        pause;
    logic        all_station;
    logic        group;
    logic        deferred;
    logic        late_hit;
    logic        abandoned;
    logic [3:0]  hits;
  } tx_frame_t;

  typedef logic [NUM_CTRS-1:0][10:0] ctr_add_t;
endpackage

// ==== design/stat_counter_bank.sv ====
// one port's statistics counters with clear on readout
`timescale 1ns/10ps
module stat_counter_bank (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire sw_mgmt_pkg::ctr_add_t add,
  input  wire logic                  rd_en,
  input  wire logic [4:0]            rd_idx,
  output sw_mgmt_pkg::mib_word_t     rd_word
);
  import sw_mgmt_pkg::*;

  typedef struct packed {
    logic [NUM_CTRS-1:0][29:0] cnt;
    logic [NUM_CTRS-1:0]       ovf;
  } bank_state_t;

  bank_state_t st;
  bank_state_t nxt;

  // clear on readout, then add; an event in the clearing cycle survives
  always_comb begin
    logic        clr;
    logic [30:0] sum;
    clr = 1'b0;
    sum = '0;
    nxt = st;
    for (int i = 0; i < NUM_CTRS; i++) begin
      clr = rd_en && (rd_idx == 5'(i));
      sum = {1'b0, (clr ? 30'h0 : st.cnt[i])} + {20'h0, add[i]};
      nxt.cnt[i] = sum[29:0];
      nxt.ovf[i] = (st.ovf[i] && !clr) || sum[30];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // word as it stands before the clear takes effect
  assign rd_word = '{overflow: st.ovf[rd_idx], valid: 1'b1, count: st.cnt[rd_idx]};
endmodule

// ==== design/learned_table.sv ====
// learned address table store with occupancy count and shared read port
`timescale 1ns/10ps
module learned_table (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire sw_mgmt_pkg::learn_wr_t learn,
  input  wire logic                   rd_en,
  input  wire logic [9:0]             rd_index,
  output logic                        rd_done,
  output sw_mgmt_pkg::entry_t         rd_entry,
  output logic                        rd_present,
  output logic [10:0]                 count
);
  import sw_mgmt_pkg::*;

  typedef struct packed {
    logic [TBL_DEPTH-1:0] present;
    logic [10:0]          count;
    logic                 pend;
    logic [9:0]           idx;
    logic                 done;
    logic                 hit;
  } tbl_state_t;

  tbl_state_t st;
  tbl_state_t nxt;
  entry_t     mem [TBL_DEPTH];
  entry_t     rd_q;
  logic       serve;

  // learning owns the memory port; a host read waits behind it
  assign serve = st.pend && !learn.en && !rd_en;

  always_comb begin
    nxt = st;
    nxt.done = serve;
    if (serve) begin
      nxt.pend = 1'b0;
      nxt.hit = st.present[st.idx];
    end
    if (rd_en) begin
      nxt.pend = 1'b1;
      nxt.idx = rd_index;
    end
    // only the learning engine alters entries
    if (learn.en) begin
      if (learn.keep && !st.present[learn.index]) begin
        nxt.count = st.count + ADD_ONE;
      end else if (!learn.keep && st.present[learn.index]) begin
        nxt.count = st.count - ADD_ONE;
      end
      nxt.present[learn.index] = learn.keep;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  // entry storage, no reset needed; stale words are masked by hit
  always_ff @(posedge pclk) begin
    if (learn.en) begin
      mem[learn.index] <= learn.entry;
    end
    if (serve) begin
      rd_q <= mem[st.idx];
    end
  end

  assign rd_done    = st.done;
  assign rd_entry   = rd_q;
  assign rd_present = st.hit;
  assign count      = st.count;
endmodule

// ==== tb/tbl_stat_sva.sv ====
// apb-side assertions for the table and statistics readout
`timescale 1ns/10ps
module tbl_stat_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr
);
  logic setup;
  logic bad;
  // setup phase and unmapped decode
  assign setup = psel && !penable;
  assign bad   = paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0 ||
                 paddr[9:2] < 8'h6e || paddr[9:2] > 8'h7a;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////
  property p_rdy; setup |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready missing after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready longer than one cycle");
  property p_idle; !setup |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("ready without setup");
  property p_err; setup && bad |=> pslverr && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; setup && !bad |=> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_wr0; setup && pwrite |=> prdata == 32'h0; endproperty
  a_wr0: assert property (p_wr0) else $error("write returned data");
  // read data must not drift between host accesses
  property p_hold; !setup |=> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data changed");
  property p_byte; setup && !pwrite |=> prdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("upper read bits set");
endmodule

bind learned_table_and_port_statistics tbl_stat_sva tbl_stat_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ==== tb/host_bfm.sv ====
// host processor model: apb master with indirect table and counter reads
`timescale 1ns/10ps
module host_bfm
  import sw_mgmt_pkg::*;
(
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             hung
);
  initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  ////////////////////////////////////////////////////////////////
  // one transfer; idle edge first so psel is never set twice in a step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 16);
    if (n >= 16) hung <= 1'b1;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] q);
    logic e;
    xfer(1'b0, {2'h0, i, 2'h0}, 8'h0, q, e);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    xfer(1'b1, {2'h0, i, 2'h0}, d, q, e);
  endtask
  // table fetch; a not-ready byte restarts from the byte holding bit 55
  task automatic tbl_rd(input logic [9:0] ix, output rec_t r);
    logic [31:0] q;
    int k;
    int t;
    wr(IDX_CTRL, {3'h0, SEL_TBL_RD, ix[9:8]});
    wr(IDX_ADDR, ix[7:0]);
    t = 0;
    // poll the ready byte first; byte 114 carries entry fields too
    rd(8'(IDX_DATA0 + 2), q);
    while (q[7] && t++ < 40) rd(8'(IDX_DATA0 + 2), q);
    if (q[7]) hung <= 1'b1;
    for (k = 0; k < 9; k++) begin
      rd(8'(IDX_DATA0 + k), q);
      r[71-8*k -: 8] = q[7:0];
    end
  endtask
  // counter fetch, word in the last four data bytes
  task automatic ctr_rd(input logic [7:0] off, output logic [31:0] w);
    logic [31:0] q;
    int k;
    wr(IDX_CTRL, {3'h0, SEL_MIB_RD, 2'h0});
    wr(IDX_ADDR, off);
    for (k = 0; k < 4; k++) begin
      rd(8'(IDX_DATA0 + 5 + k), q);
      w[31-8*k -: 8] = q[7:0];
    end
  endtask
endmodule

// ==== tb/learned_table_and_port_statistics_bench.sv ====
// self-checking bench for the table and statistics readout
`timescale 1ns/10ps
module learned_table_and_port_statistics_bench;
  import sw_mgmt_pkg::*;
  localparam entry_t E0 = '{2'h1, 3'h0, 7'h7f, 48'hffff_ffff_ffff};
  localparam entry_t E1 = '{2'h3, 3'h4, 7'h55, 48'h0123_4567_89ab};
  // counter offset and expected word: valid bit plus count, all zero for offset 0x10 outside the port blocks
  localparam logic [39:0] CTAB [12] = '{
    {8'h40, 32'h4000_0040}, {8'h41, 32'h4000_0064},
    {8'h4e, 32'h4000_0001}, {8'h4f, 32'h4000_0001},
    {8'h4d, 32'h4000_0002}, {8'h4e, 32'h4000_0000},
    {8'h2e, 32'h4000_0000}, {8'h94, 32'h4000_0050},
    {8'h9e, 32'h4000_0001}, {8'h9c, 32'h4000_0001},
    {8'h9a, 32'h4000_0001}, {8'h10, 32'h0000_0000}};
  logic                        pclk = 1'b0;
  logic                        presetn = 1'b0;
  logic                        psel, penable, pwrite, pready, pslverr, hung, e;
  logic [11:0]                 paddr;
  logic [31:0]                 pwdata, prdata, q;
  learn_wr_t                   learn_wr = '0;
  rx_frame_t [NUM_PORTS-1:0]   rx_frame = '0;
  tx_frame_t [NUM_PORTS-1:0]   tx_frame = '0;
  rec_t                        r;
  int                          num_errors = 0;
  int                          cmp_count = 0;
  always #2.5 pclk = ~pclk;
  learned_table_and_port_statistics learned_table_and_port_statistics_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .learn_wr(learn_wr), .rx_frame(rx_frame), .tx_frame(tx_frame));
  host_bfm host_bfm_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [71:0] ex, input logic [71:0] got);
    cmp_count++;
    if (got !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, got);
      num_errors++;
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // learning writes, held n cycles to stall a pending fetch
  task automatic learn(input logic [9:0] ix, input entry_t ent, input int n);
    repeat (n) begin
      @(posedge pclk);
      learn_wr <= '{en: 1'b1, index: ix, keep: 1'b1, entry: ent};
    end
    @(posedge pclk);
    learn_wr <= '0;
  endtask
  task automatic rx(input int p, input logic [10:0] len, input logic hi);
    @(posedge pclk);
    rx_frame[p] <= '{done: 1'b1, len: len, crc_ok: 1'b1, hi_prio: hi, default: '0};
    @(posedge pclk);
    rx_frame[p] <= '0;
  endtask
  // a hung handshake ends the run as a failure
  always @(posedge hung) begin
    num_errors++;
    end_sim();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    host_bfm_i.rd(IDX_DATA0, q);
    chk("reset byte 112", 72'h80, 72'(q));
    host_bfm_i.tbl_rd(10'h0, r);
    chk("empty record", REC_RST, r);
    learn(10'h0, E0, 1);
    learn(10'h100, E1, 1);
    fork
      host_bfm_i.tbl_rd(10'h100, r);
      learn(10'h0, E0, 14);
    join
    chk("entry 256", {1'b0, 10'h1, E1[59:58], E1[57:55], 1'b0, E1[54:0]}, r);
    host_bfm_i.wr(8'(IDX_DATA0 + 3), 8'h00);
    host_bfm_i.rd(8'(IDX_DATA0 + 3), q);
    chk("byte 115", 72'h01, 72'(q));
    host_bfm_i.xfer(1'b0, 12'h400, 8'h0, q, e);
    chk("unmapped", 72'h1, 72'({q, e}));
    rx(1, 11'd64, 1'b0);
    rx(1, 11'd100, 1'b1);
    @(posedge pclk);
    tx_frame[3] <= '{done: 1'b1, len: 11'd80, hits: 4'h1, default: '0};
    @(posedge pclk);
    tx_frame[3] <= '0;
    foreach (CTAB[i]) begin
      host_bfm_i.ctr_rd(CTAB[i][39:32], q);
      chk($sformatf("counter %h", CTAB[i][39:32]), 72'(CTAB[i][31:0]), 72'(q));
    end
    end_sim();
  end
endmodule
